//--- shared/dfs_defs.svh
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH

`define DFS_W_CUR 16
`define DFS_W_VOLT 16
`define DFS_W_TEMP 12
`define DFS_W_SPD 16
`define DFS_W_CMD 16
`define DFS_W_ACC 40
`define DFS_W_FLT 12
// fault bit positions
`define DFS_F_OC 0
`define DFS_F_OV 1
`define DFS_F_ABS_OV 2
`define DFS_F_PROC_OT 3
`define DFS_F_DRV_OT 4
`define DFS_F_MOT_OT 5
`define DFS_F_BIT 6
`define DFS_F_OSPD 7
`define DFS_F_UV 8
`define DFS_F_FB 9
`define DFS_F_I2 10
`define DFS_F_CFG 11
// default limits loaded at logic power-up; DFS_ABS_MAX is a fixed limit, never loaded
`define DFS_DEF_PEAK 16'h0400
`define DFS_DEF_OV_DRV 16'hE000
`define DFS_DEF_UV 16'h1000
`define DFS_ABS_MAX 16'hF000
`define DFS_DEF_I2_LIM 40'h0040000000
// temperature warning margin below the critical level
`define DFS_TEMP_MARGIN 12'h040
// 1.25 = 5/4: limit = peak + peak/4
`define DFS_OC_SHIFT 2
// three-term loop update every 40 clocks = 1 MHz
`define DFS_LOOP_DIV 6'h27
`define DFS_GAIN_SHIFT 8

`endif

//--- shared/dfs_pkg.sv
`default_nettype none
package dfs_pkg;
   typedef enum logic [1:0] {
      DFS_INIT,
      DFS_DISABLED,
      DFS_ENABLED,
      DFS_FAULTED
   } dfs_state_type;
endpackage : dfs_pkg
`default_nettype wire

//--- src/dfs_loop_term.sv
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defs.svh"

// one proportional/integral/derivative stage, updated on a rate enable
module dfs_loop_term (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic run,
   input wire logic signed [15:0] setpoint,
   input wire logic signed [15:0] measured,
   input wire logic signed [15:0] kp,
   input wire logic signed [15:0] ki,
   input wire logic signed [15:0] kd,
   output logic signed [15:0] out
);
   logic signed [31:0] integ_reg, integ_next;
   logic signed [15:0] err_prev_reg, err_prev_next;
   logic signed [15:0] out_reg, out_next;
   logic signed [16:0] err;
   logic signed [16:0] derr;
   logic signed [47:0] sum;

   always_comb begin
      integ_next = integ_reg;
      err_prev_next = err_prev_reg;
      out_next = out_reg;
      err = 17'(setpoint) - 17'(measured);
      derr = err - 17'(err_prev_reg);
      sum = 48'(kp) * 48'(err) + 48'(kd) * 48'(derr)
         + 48'(ki) * 48'(signed'(integ_reg[31:16]));
      if (!run) begin
         // clear history so re-enabling starts without a stored windup
         integ_next = '0;
         err_prev_next = '0;
         out_next = '0;
      end else if (tick) begin
         integ_next = integ_reg + 32'(err);
         err_prev_next = err[15:0];
         out_next = sum[`DFS_GAIN_SHIFT +: 16];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         integ_reg <= '0;
         err_prev_reg <= '0;
         out_reg <= '0;
      end else begin
         integ_reg <= integ_next;
         err_prev_reg <= err_prev_next;
         out_reg <= out_next;
      end
   end

   assign out = out_reg;
endmodule : dfs_loop_term
`default_nettype wire

//--- src/dfs_supervisor.sv
// Notes on behaviour
// - Any phase current above 1.25 times peak setting disables the drive.
// - Supply above lower of motor and drive overvoltage limits disables drive.
// - Re-enable needs fault gone and latched faults cleared by reset.
// - Temperatures near critical raise a warning only, no disable.
// - Temperature at critical level is a latched fault shutting power stage.
// - Self-check, motor thermistor, overspeed, undervoltage, feedback loss are latched faults.
// - Running current-squared-time estimate trips a fault past its limit.
// - Supply above absolute maximum raises overvoltage fault and disables.
// - No power-up sequencing needed between bus and logic supplies.
// - At logic power-up load configuration and default limits before operating.
// - Stay disabled after init; enable only on command with no fault.
// - Commands arrive from the host link, preferably CAN.
// - Current, velocity and optional position three-term loops with host gains.
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defs.svh"

module dfs_supervisor
   import dfs_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   // decoded host commands, one-cycle pulses from the link
   input wire logic cmd_enable,
   input wire logic cmd_reset,
   input wire logic cfg_write,
   input wire logic [`DFS_W_CMD-1:0] cfg_peak_current,
   input wire logic [`DFS_W_VOLT-1:0] cfg_ov_motor,
   input wire logic [`DFS_W_VOLT-1:0] cfg_uv_limit,
   input wire logic [`DFS_W_SPD-1:0] cfg_speed_limit,
   input wire logic [`DFS_W_ACC-1:0] cfg_i2_limit,
   input wire logic [`DFS_W_TEMP-1:0] cfg_temp_crit,
   input wire logic pos_loop_on,
   input wire logic signed [15:0] kp,
   input wire logic signed [15:0] ki,
   input wire logic signed [15:0] kd,
   // configuration store handshake
   input wire logic cfg_load_done,
   // samples from the measurement front end, same clock
   input wire logic [`DFS_W_CUR-1:0] i_phase_a,
   input wire logic [`DFS_W_CUR-1:0] i_phase_b,
   input wire logic [`DFS_W_CUR-1:0] i_phase_c,
   input wire logic [`DFS_W_VOLT-1:0] v_bus,
   input wire logic [`DFS_W_TEMP-1:0] t_proc,
   input wire logic [`DFS_W_TEMP-1:0] t_drv,
   input wire logic [`DFS_W_SPD-1:0] speed,
   input wire logic signed [15:0] pos_cmd,
   input wire logic signed [15:0] pos_fb,
   input wire logic signed [15:0] vel_cmd,
   input wire logic signed [15:0] vel_fb,
   input wire logic signed [15:0] cur_fb,
   // pins from outside the clock domain
   input wire logic mot_ot_pin,
   input wire logic bit_fail_pin,
   input wire logic fb_lost_pin,
   output logic cfg_load_req,
   output logic drive_enabled,
   output logic [5:0] gate_on,
   output logic signed [15:0] current_demand,
   output logic temp_warning,
   output logic [`DFS_W_FLT-1:0] fault_latched,
   output logic [`DFS_W_FLT-1:0] fault_active
);
   localparam int NP = 3;

   dfs_state_type state_reg, state_next;
   logic [`DFS_W_FLT-1:0] flt_reg, flt_next, act;
   logic [`DFS_W_CMD-1:0] peak_reg, peak_next;
   logic [`DFS_W_VOLT-1:0] ovm_reg, ovm_next, uv_reg, uv_next;
   logic [`DFS_W_SPD-1:0] spd_reg, spd_next;
   logic [`DFS_W_ACC-1:0] i2lim_reg, i2lim_next, i2acc_reg, i2acc_next;
   logic [`DFS_W_TEMP-1:0] tcrit_reg, tcrit_next;
   logic warn_reg, warn_next;
   logic [5:0] gate_reg, gate_next;
   logic load_reg, load_next;
   logic [5:0] div_reg, div_next;
   logic tick;
   logic [2:0] sync1_reg, sync2_reg, sync3_reg, pin_reg, pin_next;
   logic [`DFS_W_CUR-1:0] iph [NP];
   logic [NP-1:0] oc_hit;
   logic [`DFS_W_CUR+1:0] oc_lim;
   logic [`DFS_W_VOLT-1:0] ov_lim;
   logic [`DFS_W_CUR-1:0] imax;
   logic [2*`DFS_W_CUR-1:0] isq;
   logic [`DFS_W_ACC-1:0] cool;
   logic signed [15:0] vel_out, cur_out;
   logic signed [15:0] vel_set;
   logic run;

   assign iph[0] = i_phase_a;
   assign iph[1] = i_phase_b;
   assign iph[2] = i_phase_c;

   // limit = 1.25 x peak, widened so it cannot wrap
   assign oc_lim = 18'(peak_reg) + 18'(peak_reg >> `DFS_OC_SHIFT);
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_phase
         assign oc_hit[gi] = 18'(iph[gi]) > oc_lim;
      end
   endgenerate

   // lower of motor and drive overvoltage limits
   assign ov_lim = (ovm_reg < `DFS_DEF_OV_DRV) ? ovm_reg : `DFS_DEF_OV_DRV;

   always_comb begin
      imax = i_phase_a;
      if (i_phase_b > imax) imax = i_phase_b;
      if (i_phase_c > imax) imax = i_phase_c;
      isq = imax * imax;
      cool = 40'(peak_reg) * 40'(peak_reg);
   end

   // present fault conditions; reading a latched set is separate
   always_comb begin
      act = '0;
      act[`DFS_F_OC] = |oc_hit;
      act[`DFS_F_OV] = v_bus > ov_lim;
      act[`DFS_F_ABS_OV] = v_bus > `DFS_ABS_MAX;
      act[`DFS_F_PROC_OT] = t_proc >= tcrit_reg;
      act[`DFS_F_DRV_OT] = t_drv >= tcrit_reg;
      act[`DFS_F_MOT_OT] = pin_reg[0];
      act[`DFS_F_BIT] = pin_reg[1];
      act[`DFS_F_OSPD] = speed > spd_reg;
      // undervoltage is ignored in init so either supply may come up first
      act[`DFS_F_UV] = (state_reg != DFS_INIT) && (v_bus < uv_reg);
      act[`DFS_F_FB] = pin_reg[2];
      act[`DFS_F_I2] = i2acc_reg > i2lim_reg;
   end

   // three-flop pin synchroniser; a change counts once stages 2 and 3 agree
   always_comb begin
      pin_next = pin_reg;
      for (int k = 0; k < 3; k++) begin
         if (sync2_reg[k] == sync3_reg[k]) pin_next[k] = sync3_reg[k];
      end
   end

   always_comb begin
      div_next = (div_reg == `DFS_LOOP_DIV) ? '0 : div_reg + 6'h01;
      tick = (div_reg == `DFS_LOOP_DIV);
   end

   always_comb begin
      state_next = state_reg;
      flt_next = flt_reg;
      peak_next = peak_reg;
      ovm_next = ovm_reg;
      uv_next = uv_reg;
      spd_next = spd_reg;
      i2lim_next = i2lim_reg;
      tcrit_next = tcrit_reg;
      load_next = 1'b0;
      i2acc_next = i2acc_reg;
      // heat in above the continuous level, drain below it
      if (tick) begin
         if (40'(isq) > cool) begin
            // saturate so a long overload cannot wrap round and hide the trip
            if (i2acc_reg > ~(40'(isq) - cool)) i2acc_next = '1;
            else i2acc_next = i2acc_reg + (40'(isq) - cool);
         end else if (i2acc_reg > (cool - 40'(isq))) begin
            i2acc_next = i2acc_reg - (cool - 40'(isq));
         end else begin
            i2acc_next = '0;
         end
      end
      // warning only, never feeds the disable path
      // one extra bit so a reading near full scale cannot wrap past the margin
      warn_next = (13'(t_proc) + 13'(`DFS_TEMP_MARGIN) >= 13'(tcrit_reg))
         || (13'(t_drv) + 13'(`DFS_TEMP_MARGIN) >= 13'(tcrit_reg));
      // reset clears only faults no longer present; a live fault stays set
      if (cmd_reset && state_reg != DFS_INIT) flt_next = act;
      else flt_next = flt_reg | act;
      // limits move only while the stage is off, so a trip level never shifts under load
      if (cfg_write && state_reg != DFS_ENABLED) begin
         peak_next = cfg_peak_current;
         ovm_next = cfg_ov_motor;
         uv_next = cfg_uv_limit;
         spd_next = cfg_speed_limit;
         i2lim_next = cfg_i2_limit;
         tcrit_next = cfg_temp_crit;
      end
      case (state_reg)
         DFS_INIT: begin
            load_next = 1'b1;
            flt_next = '0;
            if (cfg_load_done) begin
               load_next = 1'b0;
               state_next = DFS_DISABLED;
            end
         end
         DFS_DISABLED: begin
            if (cmd_enable && flt_next == '0 && act == '0) state_next = DFS_ENABLED;
         end
         DFS_ENABLED: begin
            // any present condition drops the stage; latching runs in parallel
            if (act != '0) state_next = DFS_FAULTED;
         end
         DFS_FAULTED: begin
            // host must reset before a new enable is honoured
            if (cmd_reset && act == '0) state_next = DFS_DISABLED;
         end
         default: state_next = DFS_INIT;
      endcase
      run = (state_reg == DFS_ENABLED) && (state_next == DFS_ENABLED);
      gate_next = run ? 6'h3F : 6'h00;
   end

   // position -> velocity -> current cascade
   // the position stage only steers the velocity setpoint while it is switched in
   logic signed [15:0] pos_out_w;
   assign vel_set = pos_loop_on ? pos_out_w : vel_cmd;

   dfs_loop_term u_pos (
      .clk(clk), .nrst(nrst), .tick(tick), .run(run && pos_loop_on),
      .setpoint(pos_cmd), .measured(pos_fb),
      .kp(kp), .ki(ki), .kd(kd), .out(pos_out_w)
   );
   dfs_loop_term u_vel (
      .clk(clk), .nrst(nrst), .tick(tick), .run(run),
      .setpoint(vel_set), .measured(vel_fb),
      .kp(kp), .ki(ki), .kd(kd), .out(vel_out)
   );
   dfs_loop_term u_cur (
      .clk(clk), .nrst(nrst), .tick(tick), .run(run),
      .setpoint(vel_out), .measured(cur_fb),
      .kp(kp), .ki(ki), .kd(kd), .out(cur_out)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= DFS_INIT;
         flt_reg <= '0;
         peak_reg <= `DFS_DEF_PEAK;
         ovm_reg <= `DFS_DEF_OV_DRV;
         uv_reg <= `DFS_DEF_UV;
         spd_reg <= '1;
         i2lim_reg <= `DFS_DEF_I2_LIM;
         tcrit_reg <= '1;
         warn_reg <= 1'b0;
         gate_reg <= '0;
         load_reg <= 1'b0;
         div_reg <= '0;
         i2acc_reg <= '0;
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         pin_reg <= '0;
      end else begin
         state_reg <= state_next;
         flt_reg <= flt_next;
         peak_reg <= peak_next;
         ovm_reg <= ovm_next;
         uv_reg <= uv_next;
         spd_reg <= spd_next;
         i2lim_reg <= i2lim_next;
         tcrit_reg <= tcrit_next;
         warn_reg <= warn_next;
         gate_reg <= gate_next;
         load_reg <= load_next;
         div_reg <= div_next;
         i2acc_reg <= i2acc_next;
         // stage one may go metastable; nothing but stage two reads it
         sync1_reg <= {fb_lost_pin, bit_fail_pin, mot_ot_pin};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg <= pin_next;
      end
   end

   // demand, present faults and the enable flag are registered so every output is a flop
   logic signed [15:0] dem_reg, dem_next;
   logic [`DFS_W_FLT-1:0] act_reg, act_next;
   logic en_reg, en_next;

   always_comb begin
      dem_next = run ? cur_out : 16'sh0000;
      act_next = act;
      en_next = run;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dem_reg <= '0;
         act_reg <= '0;
         en_reg <= 1'b0;
      end else begin
         dem_reg <= dem_next;
         act_reg <= act_next;
         en_reg <= en_next;
      end
   end

   assign cfg_load_req = load_reg;
   assign drive_enabled = en_reg;
   assign gate_on = gate_reg;
   assign current_demand = dem_reg;
   assign temp_warning = warn_reg;
   assign fault_latched = flt_reg;
   assign fault_active = act_reg;
endmodule : dfs_supervisor
`default_nettype wire

//--- testbench/dfs_supervisor_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defs.svh"

module dfs_supervisor_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cmd_enable,
   input wire logic [`DFS_W_CUR-1:0] i_phase_a,
   input wire logic [`DFS_W_CUR-1:0] i_phase_b,
   input wire logic [`DFS_W_CUR-1:0] i_phase_c,
   input wire logic [`DFS_W_VOLT-1:0] v_bus,
   input wire logic [`DFS_W_TEMP-1:0] t_proc,
   input wire logic [`DFS_W_TEMP-1:0] t_drv,
   input wire logic fb_lost_pin,
   input wire logic cfg_load_req,
   input wire logic drive_enabled,
   input wire logic [5:0] gate_on,
   input wire logic signed [15:0] current_demand,
   input wire logic temp_warning,
   input wire logic [`DFS_W_FLT-1:0] fault_latched
);
   // limit figures assume the default peak and a critical level of all ones
   localparam logic [15:0] OC_LIM = `DFS_DEF_PEAK + (`DFS_DEF_PEAK >> `DFS_OC_SHIFT);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic over_i;
   assign over_i = (i_phase_a > OC_LIM) || (i_phase_b > OC_LIM) || (i_phase_c > OC_LIM);
   property p_oc_trip; over_i |=> fault_latched[`DFS_F_OC]; endproperty
   a_oc_trip: assert property (p_oc_trip) else $error("overcurrent not latched");
   property p_ov_trip; (v_bus > `DFS_DEF_OV_DRV) |=> fault_latched[`DFS_F_OV]; endproperty
   a_ov_trip: assert property (p_ov_trip) else $error("overvoltage not latched");
   property p_abs_ov; (v_bus > `DFS_ABS_MAX) |=> fault_latched[`DFS_F_ABS_OV]; endproperty
   a_abs_ov: assert property (p_abs_ov) else $error("absolute overvoltage not latched");
   property p_warn; (t_proc >= 12'hFBF) |=> temp_warning; endproperty
   a_warn: assert property (p_warn) else $error("temperature warning missing");
   property p_crit; (t_drv == 12'hFFF) |=> fault_latched[`DFS_F_DRV_OT]; endproperty
   a_crit: assert property (p_crit) else $error("driver overtemperature not latched");
   property p_fb; fb_lost_pin [*6] |=> fault_latched[`DFS_F_FB]; endproperty
   a_fb: assert property (p_fb) else $error("feedback loss not latched");
   property p_kill; (|fault_latched) |=> !drive_enabled; endproperty
   a_kill: assert property (p_kill) else $error("drive still enabled with a fault");
   property p_cause; $rose(drive_enabled) |-> $past(cmd_enable, 2); endproperty
   a_cause: assert property (p_cause) else $error("enable without command");
   property p_quiet; !drive_enabled |-> (gate_on == 6'h00) && (current_demand == 16'sh0000);
   endproperty
   a_quiet: assert property (p_quiet) else $error("power stage active while disabled");
   property p_init; cfg_load_req |-> !drive_enabled ##1 !drive_enabled; endproperty
   a_init: assert property (p_init) else $error("enabled during initialisation");
   c_enable: cover property ($rose(drive_enabled));
   c_oc: cover property ($rose(fault_latched[`DFS_F_OC]));
   c_clear: cover property ($fell(|fault_latched));
endmodule : dfs_supervisor_chk

bind dfs_supervisor dfs_supervisor_chk u_chk (.clk, .nrst, .cmd_enable, .i_phase_a,
   .i_phase_b, .i_phase_c, .v_bus, .t_proc, .t_drv, .fb_lost_pin, .cfg_load_req,
   .drive_enabled, .gate_on, .current_demand, .temp_warning, .fault_latched);
`default_nettype wire

//--- testbench/dfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module dfs_host_model (
   input wire logic clk,
   output logic cmd_enable,
   output logic cmd_reset
);
   initial begin
      cmd_enable = 1'b0;
      cmd_reset = 1'b0;
   end
   // lag models a slow link; the pulse is always one whole cycle
   task automatic send(input logic is_reset, input int lag);
      repeat (lag + 1) @(negedge clk);
      if (is_reset) cmd_reset = 1'b1;
      else cmd_enable = 1'b1;
      @(negedge clk);
      cmd_enable = 1'b0;
      cmd_reset = 1'b0;
   endtask : send
endmodule : dfs_host_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected t=%0t got=%0h exp=%0h", $time, g, e); end end

module testbench;
   import dfs_pkg::*;
   logic clk, nrst, cmd_enable, cmd_reset, cfg_write, pos_loop_on, cfg_load_done;
   logic mot_ot_pin, bit_fail_pin, fb_lost_pin, cfg_load_req, drive_enabled, temp_warning;
   logic [15:0] cfg_peak_current, cfg_ov_motor, cfg_uv_limit, cfg_speed_limit;
   logic [15:0] i_phase_a, i_phase_b, i_phase_c, v_bus, speed;
   logic [39:0] cfg_i2_limit;
   logic [11:0] cfg_temp_crit, t_proc, t_drv, fault_latched, fault_active;
   logic signed [15:0] kp, ki, kd, pos_cmd, pos_fb, vel_cmd, vel_fb, cur_fb, current_demand;
   logic [5:0] gate_on;
   int fail_count = 0;
   int n_compared = 0;
   int seed;

   dfs_supervisor u_dut (.clk, .nrst, .cmd_enable, .cmd_reset, .cfg_write, .cfg_peak_current,
      .cfg_ov_motor, .cfg_uv_limit, .cfg_speed_limit, .cfg_i2_limit, .cfg_temp_crit,
      .pos_loop_on, .kp, .ki, .kd, .cfg_load_done, .i_phase_a, .i_phase_b, .i_phase_c,
      .v_bus, .t_proc, .t_drv, .speed, .pos_cmd, .pos_fb, .vel_cmd, .vel_fb, .cur_fb,
      .mot_ot_pin, .bit_fail_pin, .fb_lost_pin, .cfg_load_req, .drive_enabled, .gate_on,
      .current_demand, .temp_warning, .fault_latched, .fault_active);
   dfs_host_model u_host (.clk, .cmd_enable, .cmd_reset);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [15:0] oc_lim(input logic [15:0] p);
      return p + (p >> `DFS_OC_SHIFT);
   endfunction : oc_lim

   // cause index k equals the fault bit position it should latch
   task automatic cause(input int k, input logic on);
      case (k)
         0: i_phase_b = on ? oc_lim(cfg_peak_current) + 16'h0001 : 16'h0010;
         1: v_bus = on ? cfg_ov_motor + 16'h0001 : 16'h8000;
         2: v_bus = on ? `DFS_ABS_MAX + 16'h0001 : 16'h8000;
         3: t_proc = on ? cfg_temp_crit : 12'h100;
         4: t_drv = on ? cfg_temp_crit : 12'h100;
         5: mot_ot_pin = on;
         6: bit_fail_pin = on;
         7: speed = on ? cfg_speed_limit + 16'h0001 : 16'h0000;
         8: v_bus = on ? cfg_uv_limit - 16'h0001 : 16'h8000;
         default: fb_lost_pin = on;
      endcase
   endtask : cause

   task automatic enable_chk(input int lag, input logic exp);
      u_host.send(1'b0, lag);
      repeat (2) @(negedge clk);
      `CHK(drive_enabled, exp)
      `CHK(gate_on, exp ? 6'h3F : 6'h00)
   endtask : enable_chk

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   initial begin
      #(25 * 3000);
      fail_count++;
      conclude();
   end

   initial begin
      {nrst, cfg_write, pos_loop_on, cfg_load_done, mot_ot_pin, bit_fail_pin} = '0;
      {fb_lost_pin, i_phase_a, i_phase_b, i_phase_c, speed, t_proc, t_drv} = '0;
      {kp, ki, kd, pos_cmd, pos_fb, vel_cmd, vel_fb, cur_fb} = '0;
      v_bus = 16'h8000;
      cfg_peak_current = `DFS_DEF_PEAK;
      cfg_ov_motor = 16'hD000;
      cfg_uv_limit = `DFS_DEF_UV;
      cfg_speed_limit = 16'h8000;
      cfg_i2_limit = `DFS_DEF_I2_LIM;
      cfg_temp_crit = 12'hFFF;
      seed = $urandom(45);
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      `CHK(cfg_load_req, 1'b1)
      enable_chk(0, 1'b0);
      cfg_load_done = 1'b1;
      @(negedge clk);
      cfg_write = 1'b1;
      @(negedge clk);
      cfg_write = 1'b0;
      enable_chk(1, 1'b1);
      for (int k = 0; k < 10; k++) begin
         cause(k, 1'b1);
         repeat (6) @(negedge clk);
         `CHK(fault_latched[k], 1'b1)
         `CHK(fault_active[k], 1'b1)
         `CHK(drive_enabled, 1'b0)
         enable_chk(0, 1'b0);
         // a reset while the cause persists must not clear the fault
         u_host.send(1'b1, 0);
         @(negedge clk);
         `CHK(fault_latched[k], 1'b1)
         cause(k, 1'b0);
         repeat (6) @(negedge clk);
         u_host.send(1'b1, k % 3);
         @(negedge clk);
         `CHK(fault_latched, 12'h000)
         enable_chk(k % 2, 1'b1);
      end
      // overcurrent limit itself is not a trip, only values above it
      i_phase_c = oc_lim(cfg_peak_current);
      repeat (30) begin
         i_phase_a = 16'($urandom_range(16'h3F, 0));
         t_proc = 12'hFBF + 12'($urandom_range(12'h3E, 0));
         t_drv = 12'($urandom_range(12'hF00, 0));
         {kp, ki, kd, pos_cmd} = {$urandom, $urandom};
         {pos_fb, vel_cmd, vel_fb, cur_fb} = {$urandom, $urandom};
         pos_loop_on = 1'($urandom_range(1, 0));
         @(negedge clk);
      end
      `CHK(temp_warning, 1'b1)
      `CHK(drive_enabled, 1'b1)
      `CHK(fault_latched, 12'h000)
      // unity proportional gain on velocity and current loops passes the command through
      {ki, kd, vel_fb, cur_fb} = '0;
      kp = 16'sh0001 << `DFS_GAIN_SHIFT;
      pos_loop_on = 1'b0;
      vel_cmd = 16'sh0123;
      repeat (120) @(negedge clk);
      `CHK(current_demand, 16'sh0123)
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(drive_enabled, 1'b0)
      // small heat budget with a phase held above peak must trip and lock out
      cfg_i2_limit = 40'h0000100000;
      cfg_write = 1'b1;
      @(negedge clk);
      cfg_write = 1'b0;
      repeat (120) @(negedge clk);
      `CHK(fault_latched[`DFS_F_I2], 1'b1)
      enable_chk(0, 1'b0);
      conclude();
   end
endmodule : testbench
`default_nettype wire
